// [core/keypad_wake_module.sv]
// keypad wake module: pin event detection, sticky flag, request and wake outputs
// assumes key_input_pin synchronous to aclk and aclk kept running in wait/stop
//
// Notes on behaviour
// [R1] enable bits 5,4,2:0 gate detection
// [R2] polarity bit: 0 falling/low, 1 rising/high
// [R3] control bit 0 selects edge or edge+level
// [R4] control bit 1 gates the interrupt request
// [R5] bit 3 read-only event flag
// [R6] bit 2 write-one acknowledge, reads zero
// [R7] falling edge: 1 then 0 on cycles
// [R8] rising edge: 0 then 1 on cycles
// [R9] deasserted sample needed before an edge
// [R10] valid edge sets flag, request if enabled
// [R11] level mode: edge or level sets flag
// [R12] level mode ack clears only when all deasserted
// [R13] keeps working in wait, wakes device
// [R14] detects in stop, wakes device
// [R15] debug mode behaves as normal run
// [R16] enabling pins turns on no pulls
// [R17] software init order avoids false interrupt
// [R18] three 8-bit registers
// [R19] request equals flag and irq enable
// [R20] unimplemented bits read zero, ignore writes
//
// Local design decisions: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module keypad_wake_module (
	input  wire logic                          aclk,
	input  wire logic                          aresetn,
	input  wire logic [keypad_wake_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                          s_axi_awvalid,
	output logic                               s_axi_awready,
	input  wire logic [31:0]                   s_axi_wdata,
	input  wire logic [3:0]                    s_axi_wstrb,
	input  wire logic                          s_axi_wvalid,
	output logic                               s_axi_wready,
	output logic [1:0]                         s_axi_bresp,
	output logic                               s_axi_bvalid,
	input  wire logic                          s_axi_bready,
	input  wire logic [keypad_wake_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                          s_axi_arvalid,
	output logic                               s_axi_arready,
	output logic [31:0]                        s_axi_rdata,
	output logic [1:0]                         s_axi_rresp,
	output logic                               s_axi_rvalid,
	input  wire logic                          s_axi_rready,
	input  wire logic [keypad_wake_pkg::NUM_PINS-1:0] key_input_pin,
	output logic                               key_irq_req,
	output logic                               wake_req
);
	import keypad_wake_pkg::*;

	logic [ADDR_W-1:0] wr_addr;
	logic [ADDR_W-1:0] rd_addr;
	logic              wr_en;
	logic              rd_en;
	logic [7:0]        wr_data;
	logic [7:0]        rd_data;
	logic              wr_ok;
	logic              rd_ok;
	logic              level_detect_mode_r;
	logic              key_irq_en_r;
	logic              key_event_flag_r;
	logic [7:0]        key_input_enable_r;
	logic [7:0]        key_polarity_select_r;
	logic [NUM_PINS-1:0] edge_hit;
	logic [NUM_PINS-1:0] level_hit;
	logic              set_flag;
	logic              ack_wr;
	logic              clear_ok;
	logic [7:0]        status_control_rd;

	key_axi_slave #(
		.AW(ADDR_W)
	) u_bus (
		.aclk         (aclk),
		.aresetn      (aresetn),
		.s_axi_awaddr (s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata  (s_axi_wdata),
		.s_axi_wstrb  (s_axi_wstrb),
		.s_axi_wvalid (s_axi_wvalid),
		.s_axi_wready (s_axi_wready),
		.s_axi_bresp  (s_axi_bresp),
		.s_axi_bvalid (s_axi_bvalid),
		.s_axi_bready (s_axi_bready),
		.s_axi_araddr (s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata  (s_axi_rdata),
		.s_axi_rresp  (s_axi_rresp),
		.s_axi_rvalid (s_axi_rvalid),
		.s_axi_rready (s_axi_rready),
		.wr_en        (wr_en),
		.wr_addr      (wr_addr),
		.wr_data      (wr_data),
		.wr_ok        (wr_ok),
		.rd_en        (rd_en),
		.rd_addr      (rd_addr),
		.rd_data      (rd_data),
		.rd_ok        (rd_ok)
	);

	// detection runs regardless of run, wait, stop or debug state; see [R13] [R14] [R15]
	key_pin_detect #(
		.N(NUM_PINS)
	) u_detect (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.pins     (key_input_pin),
		.enable   (key_input_enable_r[NUM_PINS-1:0]),
		.polarity (key_polarity_select_r[NUM_PINS-1:0]),
		.edge_hit (edge_hit),
		.level_hit(level_hit)
	);

	assign wr_ok = (wr_addr == OFF_STATUS_CONTROL) || (wr_addr == OFF_INPUT_ENABLE)
		|| (wr_addr == OFF_POLARITY_SELECT);
	assign rd_ok = (rd_addr == OFF_STATUS_CONTROL) || (rd_addr == OFF_INPUT_ENABLE)
		|| (rd_addr == OFF_POLARITY_SELECT);

	// edge always counts, level only in level mode; see [R10] [R11] [R3]
	assign set_flag = (|edge_hit) || (level_detect_mode_r && (|level_hit));
	assign ack_wr = wr_en && (wr_addr == OFF_STATUS_CONTROL) && wr_data[BIT_FLAG_ACK]; // see [R6]
	// in level mode an asserted enabled pin blocks the clear; see [R12]
	assign clear_ok = !level_detect_mode_r || !(|level_hit);

	// control bits of the status/control register; see [R3] [R4] [R18]
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			level_detect_mode_r <= RESET_STATUS_CONTROL[BIT_LEVEL_MODE];
			key_irq_en_r <= RESET_STATUS_CONTROL[BIT_IRQ_EN];
		end else if (wr_en && wr_addr == OFF_STATUS_CONTROL) begin
			level_detect_mode_r <= wr_data[BIT_LEVEL_MODE];
			key_irq_en_r <= wr_data[BIT_IRQ_EN];
		end
	end

	// only the pin bits are stored, others stay zero; see [R1] [R20]
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			key_input_enable_r <= RESET_INPUT_ENABLE;
		end else if (wr_en && wr_addr == OFF_INPUT_ENABLE) begin
			key_input_enable_r <= wr_data & PIN_MASK;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			key_polarity_select_r <= RESET_POLARITY_SELECT;
		end else if (wr_en && wr_addr == OFF_POLARITY_SELECT) begin
			key_polarity_select_r <= wr_data & PIN_MASK; // see [R2] [R20]
		end
	end

	// flag is only written by hardware; set wins over a same-cycle ack; see [R5]
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			key_event_flag_r <= RESET_STATUS_CONTROL[BIT_EVENT_FLAG];
		end else if (set_flag) begin
			key_event_flag_r <= 1'b1; // see [R10] [R11]
		end else if (ack_wr && clear_ok) begin
			key_event_flag_r <= 1'b0; // see [R6] [R12]
		end
	end

	// request and wake follow the flag gated by irq enable; see [R4] [R19]
	assign key_irq_req = key_event_flag_r && key_irq_en_r;
	// no pull controls exist here; pulls belong to the port block; see [R16]
	assign wake_req = key_irq_req; // see [R13] [R14]

	// ack bit and unused bits read zero; see [R6] [R20]
	always_comb begin
		status_control_rd = 8'h00;
		status_control_rd[BIT_LEVEL_MODE] = level_detect_mode_r;
		status_control_rd[BIT_IRQ_EN] = key_irq_en_r;
		status_control_rd[BIT_EVENT_FLAG] = key_event_flag_r;
	end

	always_comb begin
		unique case (rd_addr)
			OFF_STATUS_CONTROL: rd_data = status_control_rd;
			OFF_INPUT_ENABLE: rd_data = key_input_enable_r;
			OFF_POLARITY_SELECT: rd_data = key_polarity_select_r;
			default: rd_data = 8'h00;
		endcase
	end
endmodule
`default_nettype wire

// [shared/keypad_wake_pkg.sv]
// constants for the keypad wake module: register map, field positions, resets
// assumes a 32-bit axi4-lite register bus with word-aligned registers
package keypad_wake_pkg;
	localparam int ADDR_W = 4;
	localparam int NUM_PINS = 6;
	localparam logic [ADDR_W-1:0] OFF_STATUS_CONTROL = 4'h0;
	localparam logic [ADDR_W-1:0] OFF_INPUT_ENABLE = 4'h4;
	localparam logic [ADDR_W-1:0] OFF_POLARITY_SELECT = 4'h8;
	localparam int BIT_LEVEL_MODE = 0;
	localparam int BIT_IRQ_EN = 1;
	localparam int BIT_FLAG_ACK = 2;
	localparam int BIT_EVENT_FLAG = 3;
	localparam logic [7:0] PIN_MASK = 8'h37;
	localparam logic [7:0] RESET_STATUS_CONTROL = 8'h00;
	localparam logic [7:0] RESET_INPUT_ENABLE = 8'h00;
	localparam logic [7:0] RESET_POLARITY_SELECT = 8'h00;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [core/key_pin_detect.sv]
// per-pin edge and level detector for the keypad wake module
// assumes pins already synchronous to aclk
`timescale 1ns/1ns
`default_nettype none
module key_pin_detect #(
	parameter int N = keypad_wake_pkg::NUM_PINS
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic [N-1:0] pins,
	input  wire logic [N-1:0] enable,
	input  wire logic [N-1:0] polarity,
	output logic      [N-1:0] edge_hit,
	output logic      [N-1:0] level_hit
);
	import keypad_wake_pkg::*;
	logic [N-1:0] prev_r;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prev_r <= '0;
		end else begin
			prev_r <= pins;
		end
	end
	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_pin
			logic asserted;
			logic was_deasserted;
			assign asserted = pins[i] ~^ polarity[i];
			assign was_deasserted = prev_r[i] ^ polarity[i];
			assign level_hit[i] = enable[i] & asserted;
			// deasserted then asserted on next bus cycle; see [R7] [R8] [R9]
			assign edge_hit[i] = enable[i] & asserted & was_deasserted;
		end
	endgenerate
endmodule
`default_nettype wire

// [core/key_axi_slave.sv]
// small axi4-lite slave front end: gives one-cycle write and read strobes
// assumes a single master, one write and one read at a time
`timescale 1ns/1ns
`default_nettype none
module key_axi_slave #(
	parameter int AW = keypad_wake_pkg::ADDR_W
) (
	input  wire logic          aclk,
	input  wire logic          aresetn,
	input  wire logic [AW-1:0] s_axi_awaddr,
	input  wire logic          s_axi_awvalid,
	output logic               s_axi_awready,
	input  wire logic [31:0]   s_axi_wdata,
	input  wire logic [3:0]    s_axi_wstrb,
	input  wire logic          s_axi_wvalid,
	output logic               s_axi_wready,
	output logic [1:0]         s_axi_bresp,
	output logic               s_axi_bvalid,
	input  wire logic          s_axi_bready,
	input  wire logic [AW-1:0] s_axi_araddr,
	input  wire logic          s_axi_arvalid,
	output logic               s_axi_arready,
	output logic [31:0]        s_axi_rdata,
	output logic [1:0]         s_axi_rresp,
	output logic               s_axi_rvalid,
	input  wire logic          s_axi_rready,
	output logic               wr_en,
	output logic [AW-1:0]      wr_addr,
	output logic [7:0]         wr_data,
	input  wire logic          wr_ok,
	output logic               rd_en,
	output logic [AW-1:0]      rd_addr,
	input  wire logic [7:0]    rd_data,
	input  wire logic          rd_ok
);
	import keypad_wake_pkg::*;
	logic          aw_held_r;
	logic          w_held_r;
	logic [AW-1:0] awaddr_r;
	logic [7:0]    wdata_r;
	logic          wlane_r;
	assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
	assign s_axi_wready = !w_held_r && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign wr_en = aw_held_r && w_held_r;
	assign wr_addr = awaddr_r;
	assign wr_data = wlane_r ? wdata_r : 8'h00;
	assign rd_en = s_axi_arvalid && s_axi_arready;
	assign rd_addr = s_axi_araddr;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			awaddr_r <= '0;
			wdata_r <= 8'h00;
			wlane_r <= 1'b0;
		end else if (wr_en) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_r <= 1'b1;
				awaddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_r <= 1'b1;
				wdata_r <= s_axi_wdata[7:0];
				wlane_r <= s_axi_wstrb[0];
			end
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (wr_en) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else if (rd_en) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= {24'h00_0000, rd_data};
			s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// [testbench/key_source_model.sv]
// key source model: drives the key pins from levels the bench commands
// assumes levels change just after a rising aclk edge
`timescale 1ns/1ns
`default_nettype none
module key_source_model (
	input  wire logic                                aclk,
	input  wire logic [keypad_wake_pkg::NUM_PINS-1:0] lvl,
	output logic      [keypad_wake_pkg::NUM_PINS-1:0] key_input_pin
);
	// levels are driven outright, no pull is implied by enabling a pin
	always_ff @(posedge aclk) begin
		key_input_pin <= lvl;
	end
endmodule
`default_nettype wire

// [testbench/key_wake_monitor.sv]
// checker for the keypad wake module ports
// assumes binding to keypad_wake_module, one clock domain
`timescale 1ns/1ns
`default_nettype none
module key_wake_monitor (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        s_axi_awready,
	input  wire logic        s_axi_wready,
	input  wire logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	input  wire logic        s_axi_arready,
	input  wire logic [31:0] s_axi_rdata,
	input  wire logic [1:0]  s_axi_rresp,
	input  wire logic        s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        key_irq_req,
	input  wire logic        wake_req
);
	import keypad_wake_pkg::*;
	logic [3:0] rd_at_r;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	always_ff @(posedge aclk) begin
		if (s_axi_arvalid && s_axi_arready)
			rd_at_r <= s_axi_araddr;
	end
	a_wake_follows_req: assert property (wake_req == key_irq_req)
		else $error("wake differs from request");
	// flag is sticky: only a register write may drop the request
	a_req_drop_write: assert property ($fell(key_irq_req) |-> $rose(s_axi_bvalid))
		else $error("request fell without a write");
	a_read_one_cycle: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid)
		else $error("read answer late");
	a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
	a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid)
		else $error("write answer dropped");
	a_busy_refuses: assert property (s_axi_bvalid
		|-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while answer pending");
	a_upper_bits_zero: assert property (s_axi_rvalid
		|-> s_axi_rdata[31:6] == 26'h0)
		else $error("unused read bits set");
	a_ack_reads_zero: assert property (s_axi_rvalid
		&& rd_at_r == OFF_STATUS_CONTROL
		|-> s_axi_rdata[2] == 1'b0 && s_axi_rdata[5:4] == 2'h0)
		else $error("ack or unused bits read back");
	a_pin3_absent: assert property (s_axi_rvalid
		&& rd_at_r != OFF_STATUS_CONTROL
		|-> !s_axi_rdata[3])
		else $error("absent pin bit read back");
	c_req_rise: cover property ($rose(key_irq_req));
	c_answer_stall: cover property (s_axi_rvalid && !s_axi_rready);
	c_slverr: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
	c_req_fall: cover property ($fell(key_irq_req));
endmodule
bind keypad_wake_module key_wake_monitor mon (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .key_irq_req(key_irq_req),
	.wake_req(wake_req));
`default_nettype wire

// [testbench/keypad_wake_module_test.sv]
// bench for the keypad wake module: register bus and pin detection
// assumes the key source model drives the pins
`timescale 1ns/1ns
`default_nettype none
module keypad_wake_module_test;
	import keypad_wake_pkg::*;
	logic aclk = 0, aresetn = 0;
	logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, key_irq_req, wake_req;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [5:0] lvl = 6'h3F, key_input_pin;
	int mismatches = 0, num_checks = 0;
	// edges the master waits before raising bready or rready
	int lag = 0;
	keypad_wake_module dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .key_input_pin(key_input_pin), .key_irq_req(key_irq_req),
		.wake_req(wake_req));
	key_source_model src (.aclk(aclk), .lvl(lvl), .key_input_pin(key_input_pin));
	task summarize;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask
	// handshakes judged on negedge samples, which equal the values at the next rising edge
	task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er);
		logic aw_t, w_t, b_t;
		logic [1:0] r;
		int n;
		n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= (lag == 0);
		b_t = 1'b0;
		while (!b_t) begin
			@(negedge aclk);
			aw_t = s_axi_awvalid && s_axi_awready;
			w_t = s_axi_wvalid && s_axi_wready;
			b_t = s_axi_bvalid && s_axi_bready;
			r = s_axi_bresp;
			@(posedge aclk);
			if (aw_t) s_axi_awvalid <= 1'b0;
			if (w_t) s_axi_wvalid <= 1'b0;
			n++;
			if (!b_t && n >= lag) s_axi_bready <= 1'b1;
		end
		s_axi_bready <= 1'b0;
		// idle edge so a following call never re-raises ready in this step
		@(posedge aclk);
		chk("bresp", {30'h0, r}, {30'h0, er});
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] ed, input logic [1:0] er);
		logic ar_t, r_t;
		logic [31:0] d;
		logic [1:0] r;
		int n;
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= (lag == 0);
		r_t = 1'b0;
		while (!r_t) begin
			@(negedge aclk);
			ar_t = s_axi_arvalid && s_axi_arready;
			r_t = s_axi_rvalid && s_axi_rready;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			if (ar_t) s_axi_arvalid <= 1'b0;
			n++;
			if (!r_t && n >= lag) s_axi_rready <= 1'b1;
		end
		s_axi_rready <= 1'b0;
		@(posedge aclk);
		chk("rdata", d, {24'h000000, ed});
		chk("rresp", {30'h0, r}, {30'h0, er});
	endtask
	task req(input logic e);
		@(negedge aclk);
		chk("irq", {31'h0, key_irq_req}, {31'h0, e});
		chk("wake", {31'h0, wake_req}, {31'h0, e});
		@(posedge aclk);
	endtask
	task pins(input logic [5:0] v);
		lvl <= v;
		repeat (3) @(posedge aclk);
	endtask
	task t_regs;
		rd(OFF_STATUS_CONTROL, 8'h00, RESP_OKAY);
		rd(OFF_INPUT_ENABLE, 8'h00, RESP_OKAY);
		wr(4'hC, 8'hFF, RESP_SLVERR);
		rd(4'hC, 8'h00, RESP_SLVERR);
		wr(OFF_STATUS_CONTROL, 8'hFF, RESP_OKAY);
		rd(OFF_STATUS_CONTROL, 8'h03, RESP_OKAY);
		wr(OFF_INPUT_ENABLE, 8'hFF, RESP_OKAY);
		rd(OFF_INPUT_ENABLE, 8'h37, RESP_OKAY);
		// late ready so both answers must stand for a few cycles
		lag = 3;
		wr(OFF_POLARITY_SELECT, 8'hFF, RESP_OKAY);
		rd(OFF_POLARITY_SELECT, 8'h37, RESP_OKAY);
		lag = 0;
		wr(OFF_STATUS_CONTROL, 8'h00, RESP_OKAY);
		$display("regs done");
	endtask
	// set-up order: mask, polarity, enables, ack, then unmask
	task t_fall;
		wr(OFF_POLARITY_SELECT, 8'h00, RESP_OKAY);
		wr(OFF_INPUT_ENABLE, 8'h01, RESP_OKAY);
		wr(OFF_STATUS_CONTROL, 8'h04, RESP_OKAY);
		wr(OFF_STATUS_CONTROL, 8'h02, RESP_OKAY);
		req(1'b0);
		pins(6'h3E);
		req(1'b1);
		rd(OFF_STATUS_CONTROL, 8'h0A, RESP_OKAY);
		wr(OFF_STATUS_CONTROL, 8'h06, RESP_OKAY);
		repeat (4) @(posedge aclk);
		req(1'b0);
		wr(OFF_STATUS_CONTROL, 8'h00, RESP_OKAY);
		pins(6'h3F);
		pins(6'h3E);
		rd(OFF_STATUS_CONTROL, 8'h08, RESP_OKAY);
		req(1'b0);
		pins(6'h3F);
		$display("falling done");
	endtask
	task t_rise;
		wr(OFF_POLARITY_SELECT, 8'h20, RESP_OKAY);
		wr(OFF_INPUT_ENABLE, 8'h30, RESP_OKAY);
		pins(6'h1F);
		wr(OFF_STATUS_CONTROL, 8'h06, RESP_OKAY);
		req(1'b0);
		pins(6'h3F);
		req(1'b1);
		wr(OFF_STATUS_CONTROL, 8'h06, RESP_OKAY);
		pins(6'h30);
		pins(6'h3F);
		req(1'b0);
		$display("rising done");
	endtask
	task t_level;
		wr(OFF_INPUT_ENABLE, 8'h00, RESP_OKAY);
		wr(OFF_POLARITY_SELECT, 8'h00, RESP_OKAY);
		pins(6'h3D);
		wr(OFF_INPUT_ENABLE, 8'h02, RESP_OKAY);
		wr(OFF_STATUS_CONTROL, 8'h06, RESP_OKAY);
		rd(OFF_STATUS_CONTROL, 8'h02, RESP_OKAY);
		wr(OFF_STATUS_CONTROL, 8'h03, RESP_OKAY);
		req(1'b1);
		wr(OFF_STATUS_CONTROL, 8'h07, RESP_OKAY);
		rd(OFF_STATUS_CONTROL, 8'h0B, RESP_OKAY);
		pins(6'h3F);
		wr(OFF_STATUS_CONTROL, 8'h07, RESP_OKAY);
		rd(OFF_STATUS_CONTROL, 8'h03, RESP_OKAY);
		req(1'b0);
		$display("level done");
	endtask
	initial begin
		forever #5 aclk = ~aclk;
	end
	// whole run is under two hundred cycles
	initial begin
		#50000;
		mismatches++;
		summarize;
	end
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_regs;
		t_fall;
		t_rise;
		t_level;
		summarize;
	end
endmodule
`default_nettype wire
